// File: rtl/iqd_demod.sv
/*
 * i/q demodulator with decimating fir, frame fifo and wishbone register file.
 * assumes adc samples arrive synchronous to sys_clk and a fifo reader downstream.
 */
`timescale 1ns/1ps

module iqd_fifo import iqd_pkg::*; #(
	parameter int WIDTH = IQD_FRAME_W,
	parameter int DEPTH = IQD_FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic push;
	logic pop;

	assign in_ready = (level != (AW+1)'(DEPTH));
	assign out_valid = (level != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			level <= level + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : iqd_fifo

module iqd_demod import iqd_pkg::*; #(
	parameter int FIFO_DEPTH = IQD_FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic adc_valid,
	input wire iqd_adc_t adc_data,
	output logic out_valid,
	input wire logic out_ready,
	output iqd_frame_t out_frame
);
	localparam int LW = $clog2(FIFO_DEPTH) + 1;
	localparam int TW = 10;

	// ************************************************
	// helpers
	// ************************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	// signed oscillator value, 14-bit magnitude plus sign
	function automatic logic signed [15:0] osc(input logic [5:0] ph);
		logic [13:0] mag;
		mag = ph[4] ? IQD_SIN_Q[4'hF - ph[3:0]] : IQD_SIN_Q[ph[3:0]];
		return ph[5] ? -$signed({2'b00, mag}) : $signed({2'b00, mag});
	endfunction : osc

	// age of staggered accumulator j within its 16m-sample window
	function automatic logic [TW-1:0] age_of(input logic [TW-1:0] c, input logic [3:0] j,
			input logic [5:0] m, input logic [TW-1:0] taps);
		logic [TW:0] a;
		a = (TW+1)'(c) + (TW+1)'(taps) - (TW+1)'(j) * (TW+1)'(m);
		if (a >= (TW+1)'(taps)) begin
			a = a - (TW+1)'(taps);
		end
		return a[TW-1:0];
	endfunction : age_of

	function automatic logic [15:0] fmt_raw(input logic [13:0] s, input iqd_fmt_t f);
		unique case (f)
			IQD_FMT_12: return {4'h0, s[13:2]};
			IQD_FMT_16: return {s, 2'b00};
			IQD_FMT_14, IQD_FMT_RSV: return {2'b00, s};
		endcase
	endfunction : fmt_raw

	// ************************************************
	// registers
	// ************************************************
	logic [8:0] ctrl;
	logic [4:0] decim;
	logic [15:0] freq;
	logic [IQD_CHANNELS-1:0][13:0] offset;
	logic [7:0] coef_addr;
	logic signed [13:0] coef_ram [IQD_COEF_DEPTH];
	logic ovf;
	logic [LW-1:0] fifo_level;
	logic wb_req;
	logic wb_wr;
	logic ovf_event;
	logic raw_mode;
	logic [5:0] m;
	logic [TW-1:0] taps;
	logic [8:0] half;
	iqd_fmt_t fmt;

	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr = wb_req && wb_we_i;
	// powered-down demodulator still lets raw samples through
	assign raw_mode = ctrl[IQD_CTRL_DISABLE] || ctrl[IQD_CTRL_BYPASS] || ctrl[IQD_CTRL_CW];
	assign m = 6'(decim) + 6'd1;
	assign taps = TW'(IQD_TAP_MUL) * TW'(m);
	assign half = 9'(IQD_COEF_MUL) * 9'(m);
	assign fmt = iqd_fmt_t'(ctrl[IQD_CTRL_FMT_LO +: 2]);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= IQD_CTRL_RESET;
			decim <= '0;
			freq <= '0;
			offset <= '0;
		end else if (wb_wr) begin
			if (wb_adr_i == IQD_REG_CTRL) begin
				ctrl <= 9'(merge(32'(ctrl), wb_dat_i, wb_sel_i));
			end
			if (wb_adr_i == IQD_REG_DECIM) begin
				decim <= 5'(merge(32'(decim), wb_dat_i, wb_sel_i));
			end
			if (wb_adr_i == IQD_REG_FREQ) begin
				freq <= 16'(merge(32'(freq), wb_dat_i, wb_sel_i));
			end
			for (int c = 0; c < IQD_CHANNELS; c++) begin
				if (wb_adr_i == IQD_REG_OFFSET0 + 8'(c) * IQD_REG_STRIDE) begin
					offset[c] <= 14'(merge(32'(offset[c]), wb_dat_i, wb_sel_i));
				end
			end
		end
	end

	// coefficient bank, address steps after each data write
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			coef_addr <= '0;
		end else if (wb_wr && wb_adr_i == IQD_REG_COEF_ADDR) begin
			coef_addr <= 8'(merge(32'(coef_addr), wb_dat_i, wb_sel_i));
		end else if (wb_wr && wb_adr_i == IQD_REG_COEF_DATA) begin
			coef_addr <= coef_addr + 8'd1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (wb_wr && wb_adr_i == IQD_REG_COEF_DATA) begin
			coef_ram[coef_addr] <= 14'(wb_dat_i);
		end
	end

	// sticky overflow; a new event beats the clear
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ovf <= 1'b0;
		end else if (ovf_event) begin
			ovf <= 1'b1;
		end else if (wb_wr && wb_adr_i == IQD_REG_STATUS && wb_sel_i[0]
				&& wb_dat_i[IQD_STAT_OVF]) begin
			ovf <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wb_dat_o <= '0;
		end else if (wb_req && !wb_we_i) begin
			wb_dat_o <= '0;
			unique case (wb_adr_i)
				IQD_REG_CTRL: wb_dat_o <= 32'(ctrl);
				IQD_REG_DECIM: wb_dat_o <= 32'(decim);
				IQD_REG_FREQ: wb_dat_o <= 32'(freq);
				IQD_REG_COEF_ADDR: wb_dat_o <= 32'(coef_addr);
				IQD_REG_COEF_DATA: wb_dat_o <= 32'(coef_ram[coef_addr]);
				IQD_REG_STATUS: begin
					wb_dat_o[IQD_STAT_OVF] <= ovf;
					wb_dat_o[IQD_STAT_ACTIVE] <= !raw_mode;
					wb_dat_o[IQD_STAT_LEVEL_LO +: LW] <= fifo_level;
				end
				default: begin
					for (int c = 0; c < IQD_CHANNELS; c++) begin
						if (wb_adr_i == IQD_REG_OFFSET0 + 8'(c) * IQD_REG_STRIDE) begin
							wb_dat_o <= 32'(offset[c]);
						end
					end
				end
			endcase
		end
	end

	// ************************************************
	// dc removal and down-conversion
	// ************************************************
	logic v1;
	logic v2;
	logic [IQD_CHANNELS-1:0][14:0] dc;
	logic [IQD_CHANNELS-1:0][15:0] mix_i;
	logic [IQD_CHANNELS-1:0][15:0] mix_q;
	logic [IQD_PHASE_W-1:0] phase;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			v1 <= 1'b0;
			dc <= '0;
		end else begin
			v1 <= adc_valid && !raw_mode;
			for (int c = 0; c < IQD_CHANNELS; c++) begin
				dc[c] <= ctrl[IQD_CTRL_BP_DC] ? 15'($signed(adc_data[c]))
					: 15'($signed(adc_data[c]) - $signed({1'b0, offset[c]}));
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			phase <= '0;
		end else if (raw_mode) begin
			phase <= '0;
		end else if (v1) begin
			phase <= phase + freq;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			v2 <= 1'b0;
			mix_i <= '0;
			mix_q <= '0;
		end else begin
			v2 <= v1 && !raw_mode;
			for (int c = 0; c < IQD_CHANNELS; c++) begin
				if (ctrl[IQD_CTRL_BP_MIX]) begin
					mix_i[c] <= 16'($signed(dc[c]));
					mix_q[c] <= '0;
				end else begin
					// cos leads sine by a quarter turn of the 6-bit phase
					// full-width product before the shift, not a 16-bit one
					mix_i[c] <= 16'((32'($signed(dc[c])) * 32'(osc(phase[15:10] + 6'h10)))
						>>> IQD_OSC_SHIFT);
					mix_q[c] <= 16'((-(32'($signed(dc[c])) * 32'(osc(phase[15:10]))))
						>>> IQD_OSC_SHIFT);
				end
			end
		end
	end

	// ************************************************
	// decimating fir
	// ************************************************
	// sixteen staggered accumulators: each one owns one output and
	// lives 16m samples; one finishes every m samples
	logic [TW-1:0] cnt;
	logic signed [IQD_ACC_W-1:0] acc [IQD_CHANNELS][2][IQD_TAP_MUL];
	logic v3;
	logic [IQD_CHANNELS-1:0][15:0] dec_i;
	logic [IQD_CHANNELS-1:0][15:0] dec_q;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= '0;
		end else if (raw_mode || (wb_wr && wb_adr_i == IQD_REG_DECIM)) begin
			cnt <= '0;
		end else if (v2) begin
			cnt <= (cnt == taps - 1'b1) ? '0 : cnt + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		logic [TW-1:0] age;
		logic [TW-1:0] idx;
		logic signed [IQD_ACC_W-1:0] sum;
		logic signed [15:0] x;
		if (!rstn) begin
			v3 <= 1'b0;
			dec_i <= '0;
			dec_q <= '0;
			for (int c = 0; c < IQD_CHANNELS; c++) begin
				for (int q = 0; q < 2; q++) begin
					for (int j = 0; j < IQD_TAP_MUL; j++) begin
						acc[c][q][j] <= '0;
					end
				end
			end
		end else begin
			v3 <= 1'b0;
			if (v2 && ctrl[IQD_CTRL_BP_DEC]) begin
				v3 <= 1'b1;
				dec_i <= mix_i;
				dec_q <= mix_q;
			end else if (v2) begin
				for (int j = 0; j < IQD_TAP_MUL; j++) begin
					age = age_of(cnt, 4'(j), m, taps);
					// second half mirrors the stored first half
					idx = (age < TW'(half)) ? age : taps - 1'b1 - age;
					for (int c = 0; c < IQD_CHANNELS; c++) begin
						for (int q = 0; q < 2; q++) begin
							x = (q == 0) ? $signed(mix_i[c]) : $signed(mix_q[c]);
							sum = IQD_ACC_W'(x) * IQD_ACC_W'(coef_ram[idx[7:0]]);
							if (age != '0) begin
								sum = sum + acc[c][q][j];
							end
							acc[c][q][j] <= sum;
							if (age == taps - 1'b1) begin
								v3 <= 1'b1;
								if (q == 0) begin
									dec_i[c] <= 16'(sum >>> IQD_FIR_SHIFT);
								end else begin
									dec_q[c] <= 16'(sum >>> IQD_FIR_SHIFT);
								end
							end
						end
					end
				end
			end
		end
	end

	// ************************************************
	// channel multiplexing and frame fifo
	// ************************************************
	iqd_frame_t pend;
	logic pend_valid;
	iqd_frame_t push_frame;
	logic push_valid;
	logic push_ready;
	iqd_frame_t first_frame;
	iqd_frame_t second_frame;
	iqd_frame_t raw_frame;
	logic raw_v;

	always_comb begin
		raw_frame.tag = IQD_TAG_RAW;
		for (int c = 0; c < IQD_CHANNELS; c++) begin
			raw_frame.word[c] = fmt_raw(adc_data[c], fmt);
		end
		first_frame.tag = IQD_TAG_FIRST;
		second_frame.tag = IQD_TAG_SECOND;
		if (ctrl[IQD_CTRL_BP_MUX]) begin
			// per subchip: its four i words, then its four q words
			for (int s = 0; s < IQD_SUB_CH; s++) begin
				first_frame.word[s] = dec_i[s];
				first_frame.word[s + IQD_SUB_CH] = dec_q[s];
				second_frame.word[s] = dec_i[s + IQD_SUB_CH];
				second_frame.word[s + IQD_SUB_CH] = dec_q[s + IQD_SUB_CH];
			end
		end else begin
			first_frame.word = dec_i;
			second_frame.word = dec_q;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			raw_v <= 1'b0;
		end else begin
			raw_v <= 1'b0;
		end
	end

	// adc cannot stall: a frame with no room is counted as overflow
	always_comb begin
		push_valid = 1'b0;
		push_frame = raw_frame;
		ovf_event = 1'b0;
		if (pend_valid) begin
			push_valid = 1'b1;
			push_frame = pend;
			ovf_event = v3 || (raw_mode && adc_valid);
		end else if (raw_mode && adc_valid) begin
			push_valid = 1'b1;
			push_frame = raw_frame;
			ovf_event = !push_ready;
		end else if (v3) begin
			push_valid = 1'b1;
			push_frame = first_frame;
			ovf_event = !push_ready;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pend_valid <= 1'b0;
			pend <= '0;
		end else if (pend_valid) begin
			pend_valid <= !push_ready;
		end else if (v3 && !raw_mode && push_ready) begin
			pend_valid <= 1'b1;
			pend <= second_frame;
		end
	end

	iqd_fifo #(
		.WIDTH(IQD_FRAME_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(push_frame),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(out_frame),
		.level(fifo_level)
	);
endmodule : iqd_demod

// File: rtl/iqd_pkg.sv
/*
 * shared constants and types of the i/q demodulator and decimator.
 * assumes a 32-bit classic wishbone slave port and eight adc lanes of 14 bits.
 */
package iqd_pkg;
	// ************************************************
	// sizes
	// ************************************************
	localparam int IQD_CHANNELS = 8;
	localparam int IQD_SUB_CH = 4;
	localparam int IQD_ADC_W = 14;
	localparam int IQD_OUT_W = 16;
	localparam int IQD_COEF_W = 14;
	localparam int IQD_M_MAX = 32;
	localparam int IQD_TAP_MUL = 16;
	localparam int IQD_COEF_MUL = 8;
	localparam int IQD_COEF_DEPTH = IQD_COEF_MUL * IQD_M_MAX;
	localparam int IQD_PHASE_W = 16;
	localparam int IQD_ACC_W = 40;
	localparam int IQD_OSC_SHIFT = 14;
	localparam int IQD_FIR_SHIFT = 13;
	localparam int IQD_FIFO_DEPTH = 32;
	localparam int IQD_SAMPLE_RATE_MSPS = 65;
	// ************************************************
	// register byte offsets
	// ************************************************
	localparam logic [7:0] IQD_REG_CTRL = 8'h00;
	localparam logic [7:0] IQD_REG_DECIM = 8'h04;
	localparam logic [7:0] IQD_REG_FREQ = 8'h08;
	localparam logic [7:0] IQD_REG_OFFSET0 = 8'h0C;
	localparam logic [7:0] IQD_REG_COEF_ADDR = 8'h30;
	localparam logic [7:0] IQD_REG_COEF_DATA = 8'h34;
	localparam logic [7:0] IQD_REG_STATUS = 8'h38;
	localparam logic [7:0] IQD_REG_STRIDE = 8'h04;
	// ************************************************
	// control and status fields
	// ************************************************
	localparam int IQD_CTRL_DISABLE = 0;
	localparam int IQD_CTRL_BYPASS = 1;
	localparam int IQD_CTRL_BP_DC = 2;
	localparam int IQD_CTRL_BP_MIX = 3;
	localparam int IQD_CTRL_BP_DEC = 4;
	localparam int IQD_CTRL_BP_MUX = 5;
	localparam int IQD_CTRL_FMT_LO = 6;
	localparam int IQD_CTRL_CW = 8;
	localparam logic [8:0] IQD_CTRL_RESET = 9'h000;
	localparam int IQD_STAT_OVF = 0;
	localparam int IQD_STAT_ACTIVE = 1;
	localparam int IQD_STAT_LEVEL_LO = 4;
	// ************************************************
	// types
	// ************************************************
	typedef enum logic [1:0] {
		IQD_FMT_14 = 2'b00,
		IQD_FMT_12 = 2'b01,
		IQD_FMT_16 = 2'b10,
		IQD_FMT_RSV = 2'b11
	} iqd_fmt_t;
	typedef enum logic [1:0] {
		IQD_TAG_RAW = 2'b00,
		IQD_TAG_FIRST = 2'b01,
		IQD_TAG_SECOND = 2'b10,
		IQD_TAG_NONE = 2'b11
	} iqd_tag_t;
	typedef struct packed {
		iqd_tag_t tag;
		logic [IQD_CHANNELS-1:0][IQD_OUT_W-1:0] word;
	} iqd_frame_t;
	typedef logic [IQD_CHANNELS-1:0][IQD_ADC_W-1:0] iqd_adc_t;
	localparam int IQD_FRAME_W = $bits(iqd_frame_t);
	// quarter sine, 14-bit magnitude at half-step phases
	localparam logic [15:0][13:0] IQD_SIN_Q = {
		14'h3FEB, 14'h3F4E, 14'h3E14, 14'h3C41, 14'h39DA, 14'h36E4, 14'h3367, 14'h2F6B,
		14'h2AFA, 14'h261F, 14'h20E6, 14'h1B5D, 14'h158F, 14'h0F8D, 14'h0964, 14'h0324
	};
endpackage : iqd_pkg

// File: verification/iqd_demod_properties.sv
/* port checker for iqd_demod.
 * assumes bind to iqd_demod, bus writes with all byte enables. */
`timescale 1ns/1ps
module iqd_demod_properties import iqd_pkg::*; #(
	parameter int FIFO_DEPTH = IQD_FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic adc_valid,
	input wire iqd_adc_t adc_data,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire iqd_frame_t out_frame
);
	logic [8:0] ctrl;
	logic lsb;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// ****************
	// control shadow
	// ****************
	// tracks ctrl from the bus, as the checker sees no internals
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= IQD_CTRL_RESET;
		end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == IQD_REG_CTRL) begin
			ctrl <= {wb_sel_i[1] ? wb_dat_i[8] : ctrl[8], wb_sel_i[0] ? wb_dat_i[7:0] : ctrl[7:0]};
		end
	end
	always_comb begin
		lsb = 1'b0;
		for (int c = 0; c < IQD_CHANNELS; c++) begin
			lsb = lsb | (|out_frame.word[c][1:0]);
		end
	end
	// ****************
	// properties
	// ****************
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_rd(logic [7:0] a);
		s_req ##0 (!wb_we_i && wb_adr_i == a);
	endsequence
	sequence s_pop1;
		out_valid && out_ready && out_frame.tag == IQD_TAG_FIRST;
	endsequence
	AST_ACK_NEXT: assert property (s_req |=> wb_ack_o)
		else $error("ack late");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	AST_UNMAPPED: assert property (s_req ##0 (!wb_we_i && wb_adr_i > 8'h38) |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	AST_CTRL_READ: assert property (s_rd(IQD_REG_CTRL) |=> wb_dat_o[8:0] == ctrl)
		else $error("ctrl readback");
	AST_DECIM_W: assert property (s_rd(IQD_REG_DECIM) |=> wb_dat_o[31:5] == 27'h0)
		else $error("decim width");
	AST_FREQ_W: assert property (s_rd(IQD_REG_FREQ) |=> wb_dat_o[31:16] == 16'h0)
		else $error("freq width");
	AST_ACTIVE: assert property (s_rd(IQD_REG_STATUS) ##0 !ctrl[1] |=>
		wb_dat_o[IQD_STAT_ACTIVE] == !(ctrl[0] || ctrl[8]))
		else $error("active flag");
	AST_RAW_PUSH: assert property (adc_valid && (ctrl[0] || ctrl[1] || ctrl[8]) |=> out_valid)
		else $error("raw sample lost");
	AST_FMT16: assert property (out_valid && out_frame.tag == IQD_TAG_RAW &&
		ctrl[7:6] == IQD_FMT_16 |-> !lsb)
		else $error("16-bit lsbs not zero");
	AST_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_frame))
		else $error("head changed");
	AST_PAIR: assert property (s_pop1 |-> ##[1:8] (out_valid && out_frame.tag == IQD_TAG_SECOND))
		else $error("second frame missing");
endmodule : iqd_demod_properties

bind iqd_demod iqd_demod_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_iqd_demod_properties (
	.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .adc_valid(adc_valid), .adc_data(adc_data),
	.out_valid(out_valid), .out_ready(out_ready), .out_frame(out_frame));

// File: verification/iqd_sink.sv
/* frame sink standing in for the capturing fpga.
 * assumes the fifo head protocol: pop on out_valid and out_ready. */
`timescale 1ns/1ps
module iqd_sink import iqd_pkg::*; (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic stall,
	input wire logic fast,
	input wire logic out_valid,
	input wire iqd_frame_t out_frame,
	output logic out_ready,
	output logic pop,
	output iqd_frame_t got
);
	logic slow;
	// slow mode takes every other cycle, like a busy capture logic
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			slow <= 1'b0;
		end else begin
			slow <= !slow;
		end
	end
	assign out_ready = !stall && (fast || slow);
	assign pop = out_valid && out_ready;
	assign got = out_frame;
endmodule : iqd_sink

// File: verification/tb.sv
/* self-checking bench for iqd_demod.
 * assumes one 20 MHz clock and the sink model at the frame side. */
`timescale 1ns/1ps
module tb import iqd_pkg::*; ;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hF;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat, r;
	logic ack, ov, ord, pop;
	logic adc_v = 1'b0;
	iqd_adc_t adc = '0;
	logic stall = 1'b0;
	logic fast = 1'b1;
	iqd_frame_t frm, got, fr, f1, f2;
	int n_errors = 0;
	int num_checks = 0;
	int np = 0;
	int n1 = 0;
	int n2 = 0;
	int k;
	logic [13:0] x;
	logic [15:0] e;
	logic [8:0] md [4] = '{9'h002, 9'h001, 9'h100, 9'h002};
	always #25 sys_clk = ~sys_clk;
	iqd_demod #(.FIFO_DEPTH(32)) u_iqd_demod (.sys_clk(sys_clk), .rstn(rstn),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .adc_valid(adc_v),
		.adc_data(adc), .out_valid(ov), .out_ready(ord), .out_frame(frm));
	iqd_sink u_iqd_sink (.sys_clk(sys_clk), .rstn(rstn), .stall(stall), .fast(fast),
		.out_valid(ov), .out_frame(frm), .out_ready(ord), .pop(pop), .got(got));
	// ****************
	// capture and tasks
	// ****************
	always @(posedge sys_clk) begin
		if (pop) begin
			np++;
			fr = got;
			if (got.tag == IQD_TAG_FIRST) begin
				n1++;
				f1 = got;
			end else if (got.tag == IQD_TAG_SECOND) begin
				n2++;
				f2 = got;
			end
		end
	end
	task chk(input string nm, input logic [31:0] s, input logic [31:0] x0);
		num_checks++;
		if (s !== x0) begin
			n_errors++;
			$display("FAIL %s exp %h seen %h", nm, x0, s);
		end
	endtask : chk
	task print_verdict;
		if (n_errors == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (ack !== 1'b1 && n < 16);
		if (ack !== 1'b1) begin
			chk("bus ack", 32'h0, 32'h1);
			print_verdict();
		end
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge sys_clk);
	endtask : bus
	task push(input logic [13:0] b, input logic [13:0] st, input int n);
		for (int c = 0; c < IQD_CHANNELS; c++) begin
			adc[c] <= b + st * c[13:0];
		end
		adc_v <= 1'b1;
		repeat (n) @(posedge sys_clk);
		adc_v <= 1'b0;
		@(posedge sys_clk);
	endtask : push
	task waitp(input int want);
		int i;
		i = 0;
		while (np < want && i < 300) begin
			@(posedge sys_clk);
			i++;
		end
		if (np < want) begin
			chk("pops", np, want);
			print_verdict();
		end
	endtask : waitp
	initial begin
		repeat (20000) @(posedge sys_clk);
		chk("run time", 32'h0, 32'h1);
		print_verdict();
	end
	// ****************
	// main sequence
	// ****************
	initial begin
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		bus(1'b0, IQD_REG_CTRL, 32'h0);
		chk("ctrl rst", r, 32'h0);
		bus(1'b0, IQD_REG_STATUS, 32'h0);
		chk("active rst", {31'h0, r[1]}, 32'h1);
		bus(1'b0, 8'hFC, 32'h0);
		chk("unmapped", r, 32'h0);
		bus(1'b1, IQD_REG_FREQ, 32'hFFFFFFFF);
		bus(1'b0, IQD_REG_FREQ, 32'h0);
		chk("freq", r, 32'h0000FFFF);
		bus(1'b1, IQD_REG_DECIM, 32'h000000FF);
		bus(1'b0, IQD_REG_DECIM, 32'h0);
		chk("decim", r, 32'h0000001F);
		// raw path in every format and every raw cause
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, IQD_REG_CTRL, {23'h0, md[i] | 9'(i << 6)});
			if (i == 1 || i == 2) begin
				bus(1'b0, IQD_REG_STATUS, 32'h0);
				chk("active off", {31'h0, r[1]}, 32'h0);
			end
			k = np + 1;
			push(14'h1235, 14'h0111, 1);
			waitp(k);
			chk("raw tag", fr.tag, IQD_TAG_RAW);
			for (int c = 0; c < IQD_CHANNELS; c++) begin
				x = 14'h1235 + 14'h0111 * c[13:0];
				e = (i == 1) ? {4'h0, x[13:2]} : (i == 2) ? {x, 2'b00} : {2'b00, x};
				chk("raw word", fr.word[c], e);
			end
		end
		// fill the fifo past full, then drain with a slow sink
		bus(1'b1, IQD_REG_CTRL, 32'h2);
		stall <= 1'b1;
		fast <= 1'b0;
		k = np;
		push(14'h0010, 14'h0, 40);
		bus(1'b0, IQD_REG_STATUS, 32'h0);
		chk("level", r[9:4], 32'd32);
		chk("ovf set", {31'h0, r[0]}, 32'h1);
		stall <= 1'b0;
		waitp(k + 32);
		repeat (10) @(posedge sys_clk);
		chk("drained", np - k, 32'd32);
		bus(1'b1, IQD_REG_STATUS, 32'h1);
		bus(1'b0, IQD_REG_STATUS, 32'h0);
		chk("ovf clr", {31'h0, r[0]}, 32'h0);
		fast <= 1'b1;
		// coefficient bank for M=4
		bus(1'b1, IQD_REG_COEF_ADDR, 32'h0);
		for (int c = 0; c < 32; c++) begin
			bus(1'b1, IQD_REG_COEF_DATA, 32'h100);
		end
		bus(1'b0, IQD_REG_COEF_ADDR, 32'h0);
		chk("coef addr", r[7:0], 32'h20);
		bus(1'b1, IQD_REG_COEF_ADDR, 32'h5);
		bus(1'b0, IQD_REG_COEF_DATA, 32'h0);
		chk("coef", r[13:0], 32'h100);
		// mixer and decimator bypassed, dc removal active
		bus(1'b1, IQD_REG_FREQ, 32'h0);
		bus(1'b1, IQD_REG_OFFSET0, 32'd30);
		bus(1'b1, IQD_REG_CTRL, 32'h18);
		k = np + 2;
		push(14'h0064, 14'h0010, 1);
		waitp(k);
		chk("i tag", f1.tag, IQD_TAG_FIRST);
		chk("dc ch0", f1.word[0], 32'h0046);
		chk("dc ch1", f1.word[1], 32'h0074);
		chk("q tag", f2.tag, IQD_TAG_SECOND);
		// mixer at phase 0: cos = 0x3FEB, sin = 0x0324 from the table
		bus(1'b1, IQD_REG_CTRL, 32'h10);
		k = np + 2;
		push(14'h0064, 14'h0010, 1);
		waitp(k);
		chk("mix i", f1.word[1], 32'h00000073);
		chk("mix q", f2.word[1], 32'h0000FFFA);
		// decimate by 4, constant input of 0x64: 64 taps of 0x100 give twice the input
		bus(1'b1, IQD_REG_OFFSET0, 32'h0);
		bus(1'b1, IQD_REG_CTRL, 32'h08);
		bus(1'b1, IQD_REG_DECIM, 32'h3);
		push(14'h0064, 14'h0, 128);
		repeat (40) @(posedge sys_clk);
		k = n1;
		push(14'h0064, 14'h0, 128);
		repeat (40) @(posedge sys_clk);
		chk("out rate", n1 - k, 32'd32);
		chk("fir out", f1.word[3], 32'h00C8);
		chk("pairs", n2, n1);
		print_verdict();
	end
endmodule : tb
